// ---- inc/iacs_map.vh ----
// register offsets, field positions, reset values and timing counts of the channel sequencer
`ifndef IACS_MAP_VH
`define IACS_MAP_VH
`define IACS_ADR_CFG 8'h00
`define IACS_ADR_MUX 8'h04
`define IACS_ADR_STAT 8'h08
`define IACS_ADR_REF 8'h0C
`define IACS_ADR_DAT 8'h10
`define IACS_ADR_CONV 8'h14
`define IACS_CFG_CDS 4
`define IACS_CFG_3CH 5
`define IACS_MUX_BLUE 4
`define IACS_MUX_GREEN 5
`define IACS_MUX_RED 6
`define IACS_MUX_ORDER 7
`define IACS_CFG_RST 9'h0_0F8
`define IACS_MUX_RST 9'h0_0C0
`define IACS_LATENCY 2'h3
`define IACS_CH_RED 2'h0
`define IACS_CH_GREEN 2'h1
`define IACS_CH_BLUE 2'h2
`endif

// ---- core/iacs_sequencer.v ----
// channel multiplexer sequencer with sampling capture and wishbone register file
`timescale 1ns/1ps
`default_nettype none
`include "iacs_map.vh"

// What this block does
// - data strobe rising edge resets the sequence to the first slot of the order; the multiplexer follows at the next conversion rise.
// - three-channel CORRELATED_DOUBLE_SAMPLING red-first: first conversion rise after strobe selects red.
// - each conversion clock rising edge, except the first after a strobe, advances to the next enabled channel.
// - converter samples the multiplexer output on each conversion clock falling edge.
// - data strobe falling edge captures data level on all active channels.
// - in CORRELATED_DOUBLE_SAMPLING, reference strobe fall captures reference; output is reference minus data.
// - six modes from channel count and sampling method, chosen only by registers.
// - converted data appears three conversion clock cycles after sampling.
// - two-channel mode when the three-channel bit is cleared and exactly two channel-select bits are set.
// - two-channel pairs RG, RB, GB; order bit high puts upper colour first.
// - one-channel mode holds the multiplexer fixed on the selected channel.
// - sample-and-hold keeps clamp off and samples against the offset input.
// - sampling-method bit set selects CORRELATED_DOUBLE_SAMPLING, cleared selects sample-and-hold.
// - channel-select bits: highest red, middle green, lowest blue; set enables.
// - order bit cleared makes the strobe reset the multiplexer to blue first in three-channel mode.
module iacs_sequencer #(
	parameter DW = 16
) (
	// system
	input wire clk,
	input wire arst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// sampling strobes from timing controller
	input wire reference_sample_strobe,
	input wire data_sample_strobe,
	input wire conversion_clock,
	// per-channel input levels, red green blue
	input wire [DW-1:0] vin_red,
	input wire [DW-1:0] vin_green,
	input wire [DW-1:0] vin_blue,
	input wire [DW-1:0] offset_level,
	// outputs
	output reg [1:0] mux_channel_r,
	output reg [DW-1:0] conv_data_r,
	output reg [1:0] conv_channel_r,
	output reg conv_valid_r,
	output reg clamp_enable_r,
	output reg mode_error_r
);
	localparam [2:0] ST_FIRST = 3'b001;
	localparam [2:0] ST_SECOND = 3'b010;
	localparam [2:0] ST_THIRD = 3'b100;

	reg [8:0] cfg_r;
	reg [8:0] mux_cfg_r;
	reg ref_d_r;
	reg dat_d_r;
	reg conv_d_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;

	// hold registers per channel, indexed red, green, blue
	reg [DW-1:0] ref_hold_r [0:2];
	reg [DW-1:0] dat_hold_r [0:2];
	reg [DW-1:0] pipe_data_r [0:2];
	reg [1:0] pipe_ch_r [0:2];
	reg [2:0] pipe_vld_r;

	reg [1:0] slot_ch [0:2];
	reg [1:0] nchan;
	integer i;

	wire cds_on = cfg_r[`IACS_CFG_CDS];
	wire three_on = cfg_r[`IACS_CFG_3CH];
	wire order_rgb = mux_cfg_r[`IACS_MUX_ORDER];
	wire sel_r = mux_cfg_r[`IACS_MUX_RED];
	wire sel_g = mux_cfg_r[`IACS_MUX_GREEN];
	wire sel_b = mux_cfg_r[`IACS_MUX_BLUE];
	// count of enabled channels picks two- or one-channel operation
	wire [1:0] sel_count = {1'b0, sel_r} + {1'b0, sel_g} + {1'b0, sel_b};
	wire bad_mode = !three_on && (sel_count == 2'd0 || sel_count == 2'd3);

	// pins are taken as synchronous: one delayed copy finds edges, no synchroniser
	function edge_of;
		input now;
		input prev;
		input rising;
		begin
			edge_of = rising ? (now && !prev) : (!now && prev);
		end
	endfunction

	wire dat_rise = edge_of(data_sample_strobe, dat_d_r, 1'b1);
	wire dat_fall = edge_of(data_sample_strobe, dat_d_r, 1'b0);
	wire ref_fall = edge_of(reference_sample_strobe, ref_d_r, 1'b0);
	wire conv_rise = edge_of(conversion_clock, conv_d_r, 1'b1);
	wire conv_fall = edge_of(conversion_clock, conv_d_r, 1'b0);

	function [1:0] chan_of;
		input [1:0] idx;
		input [1:0] first;
		input [1:0] second;
		input [1:0] third;
		begin
			case (idx)
				2'd0: chan_of = first;
				2'd1: chan_of = second;
				default: chan_of = third;
			endcase
		end
	endfunction

	// slot table built from mode and order bits
	always @* begin
		nchan = 2'd3;
		slot_ch[0] = `IACS_CH_RED;
		slot_ch[1] = `IACS_CH_GREEN;
		slot_ch[2] = `IACS_CH_BLUE;
		if (three_on) begin
			nchan = 2'd3;
			if (!order_rgb) begin
				slot_ch[0] = `IACS_CH_BLUE;
				slot_ch[2] = `IACS_CH_RED;
			end
		end else if (sel_count == 2'd2) begin
			nchan = 2'd2;
			// upper-listed pair first when order set, else reversed
			if (!sel_b) begin
				slot_ch[0] = `IACS_CH_RED;
				slot_ch[1] = `IACS_CH_GREEN;
			end else if (!sel_g) begin
				slot_ch[0] = `IACS_CH_RED;
				slot_ch[1] = `IACS_CH_BLUE;
			end else begin
				slot_ch[0] = `IACS_CH_GREEN;
				slot_ch[1] = `IACS_CH_BLUE;
			end
			if (!order_rgb) begin
				slot_ch[2] = slot_ch[0];
				slot_ch[0] = slot_ch[1];
				slot_ch[1] = slot_ch[2];
			end
			// third slot repeats the first so a stray rise never picks a disabled channel
			slot_ch[2] = slot_ch[0];
		end else begin
			// one select bit; zero or three land here too and are flagged
			nchan = 2'd1;
			slot_ch[0] = sel_r ? `IACS_CH_RED : (sel_g ? `IACS_CH_GREEN : `IACS_CH_BLUE);
			slot_ch[1] = slot_ch[0];
			slot_ch[2] = slot_ch[0];
		end
	end

	// multiplexer advance, wraps after the last enabled slot
	// a strobe rise outranks a conversion rise in the same clock
	always @* begin
		state_nxt = state_r;
		if (dat_rise)
			state_nxt = ST_FIRST;
		else if (conv_rise) begin
			case (state_r)
				ST_FIRST: state_nxt = (nchan == 2'd1) ? ST_FIRST : ST_SECOND;
				ST_SECOND: state_nxt = (nchan == 2'd3) ? ST_THIRD : ST_FIRST;
				ST_THIRD: state_nxt = ST_FIRST;
				default: state_nxt = ST_FIRST;
			endcase
		end
	end

	// one-hot state to slot index
	function [1:0] idx_of;
		input [2:0] st;
		begin
			case (st)
				ST_SECOND: idx_of = 2'd1;
				ST_THIRD: idx_of = 2'd2;
				default: idx_of = 2'd0;
			endcase
		end
	endfunction

	// the strobe rise only arms; the next conversion rise selects slot one
	// without advancing, so the first slot of the order is converted first
	reg armed_r;
	wire [1:0] cur_idx = idx_of(state_r);

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_d_r <= 1'b0;
			dat_d_r <= 1'b0;
			conv_d_r <= 1'b0;
			state_r <= ST_FIRST;
			armed_r <= 1'b0;
			mux_channel_r <= 2'h0;
			clamp_enable_r <= 1'b1;
			mode_error_r <= 1'b0;
		end else begin
			ref_d_r <= reference_sample_strobe;
			dat_d_r <= data_sample_strobe;
			conv_d_r <= conversion_clock;
			// clamp only in correlated double sampling
			clamp_enable_r <= cds_on;
			mode_error_r <= bad_mode;
			if (dat_rise) begin
				state_r <= ST_FIRST;
				armed_r <= 1'b1;
			end else if (conv_rise && armed_r) begin
				armed_r <= 1'b0;
				mux_channel_r <= slot_ch[0];
			end else begin
				state_r <= state_nxt;
				if (conv_rise)
					mux_channel_r <= chan_of(idx_of(state_nxt), slot_ch[0], slot_ch[1], slot_ch[2]);
			end
		end
	end

	// pixel capture on strobe falls; sample-and-hold references the offset input
	// in sample-and-hold the offset holds track continuously, so a change into it needs no extra strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < 3; i = i + 1) begin
				ref_hold_r[i] <= {DW{1'b0}};
				dat_hold_r[i] <= {DW{1'b0}};
			end
		end else begin
			if (cds_on && ref_fall) begin
				ref_hold_r[0] <= vin_red;
				ref_hold_r[1] <= vin_green;
				ref_hold_r[2] <= vin_blue;
			end else if (!cds_on) begin
				ref_hold_r[0] <= offset_level;
				ref_hold_r[1] <= offset_level;
				ref_hold_r[2] <= offset_level;
			end
			if (dat_fall) begin
				dat_hold_r[0] <= vin_red;
				dat_hold_r[1] <= vin_green;
				dat_hold_r[2] <= vin_blue;
			end
		end
	end

	// a negative difference clips to zero instead of wrapping to full scale
	function [DW-1:0] diff;
		input [DW-1:0] a;
		input [DW-1:0] b;
		begin
			diff = (a > b) ? a - b : {DW{1'b0}};
		end
	endfunction

	// converter samples on conversion fall, result after three conversion clock cycles
	// the pipe moves only on conversion falls: latency counts conversion cycles
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < 3; i = i + 1) begin
				pipe_data_r[i] <= {DW{1'b0}};
				pipe_ch_r[i] <= 2'h0;
			end
			pipe_vld_r <= 3'h0;
			conv_data_r <= {DW{1'b0}};
			conv_channel_r <= 2'h0;
			conv_valid_r <= 1'b0;
		end else begin
			conv_valid_r <= 1'b0;
			if (conv_fall) begin
				pipe_data_r[0] <= cds_on ? diff(ref_hold_r[mux_channel_r], dat_hold_r[mux_channel_r]) :
					diff(dat_hold_r[mux_channel_r], ref_hold_r[mux_channel_r]);
				pipe_ch_r[0] <= mux_channel_r;
				pipe_vld_r[0] <= !bad_mode;
				pipe_data_r[1] <= pipe_data_r[0];
				pipe_ch_r[1] <= pipe_ch_r[0];
				pipe_data_r[2] <= pipe_data_r[1];
				pipe_ch_r[2] <= pipe_ch_r[1];
				pipe_vld_r[2:1] <= pipe_vld_r[1:0];
				conv_data_r <= pipe_data_r[2];
				conv_channel_r <= pipe_ch_r[2];
				// gated here too: samples taken before a bad write still sit in the pipe
				conv_valid_r <= pipe_vld_r[2] && !bad_mode;
			end
		end
	end

	// wishbone slave, one wait state free, ack one cycle after request
	// ack low in the test keeps a held request from being taken twice
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire hit_cfg = (wb_adr_i == `IACS_ADR_CFG);
	wire hit_mux = (wb_adr_i == `IACS_ADR_MUX);
	// status: slot index, selected channel, channel count, clamp, error
	wire [31:0] stat_word = {24'h00_0000, cur_idx, mux_channel_r, nchan, clamp_enable_r, mode_error_r};

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			// power-on: red first, three channels, correlated double sampling
			cfg_r <= `IACS_CFG_RST;
			mux_cfg_r <= `IACS_MUX_RST;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i) begin
				// modes change only here, never from pins; lanes two and three are unused
				if (hit_cfg) begin
					if (wb_sel_i[0]) cfg_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) cfg_r[8] <= wb_dat_i[8];
				end
				if (hit_mux) begin
					if (wb_sel_i[0]) mux_cfg_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) mux_cfg_r[8] <= wb_dat_i[8];
				end
			end
			// read data is registered with the ack, so it stands while ack is high
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					`IACS_ADR_CFG: wb_dat_o <= {23'h00_0000, cfg_r};
					`IACS_ADR_MUX: wb_dat_o <= {23'h00_0000, mux_cfg_r};
					`IACS_ADR_STAT: wb_dat_o <= stat_word;
					`IACS_ADR_REF: wb_dat_o <= {{(32-DW){1'b0}}, ref_hold_r[mux_channel_r]};
					`IACS_ADR_DAT: wb_dat_o <= {{(32-DW){1'b0}}, dat_hold_r[mux_channel_r]};
					`IACS_ADR_CONV: wb_dat_o <= {14'h0000, conv_channel_r, conv_data_r};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // iacs_sequencer
`default_nettype wire

// ---- verification/iacs_sva.sv ----
// port checker for the channel sequencer
`timescale 1ns/1ps
`default_nettype none
module iacs_sva (
	// clock
	input wire logic clk,
	input wire logic arst_n,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_ack_o,
	// link
	input wire logic data_sample_strobe,
	input wire logic conversion_clock,
	input wire logic [1:0] mux_channel_r,
	input wire logic conv_valid_r,
	input wire logic mode_error_r
);
	logic d_r, c_r;
	// clocks since a mux cause or a fall, saturating
	logic [3:0] act_r, fall_r;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			d_r <= 1'b0;
			c_r <= 1'b0;
			act_r <= 4'hf;
			fall_r <= 4'hf;
		end else begin
			d_r <= data_sample_strobe;
			c_r <= conversion_clock;
			act_r <= (data_sample_strobe & ~d_r) | (conversion_clock & ~c_r) | wb_cyc_i ? 4'h0 : act_r + {3'h0, ~&act_r};
			fall_r <= c_r & ~conversion_clock ? 4'h0 : fall_r + {3'h0, ~&fall_r};
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_ack; wb_cyc_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("long ack");
	property p_ack_idle; !wb_cyc_i |=> !wb_ack_o; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
	property p_mux; $changed(mux_channel_r) |-> act_r <= 4'h4; endproperty
	a_mux: assert property (p_mux) else $error("mux moved");
	property p_mux_ok; mux_channel_r != 2'h3; endproperty
	a_mux_ok: assert property (p_mux_ok) else $error("bad channel");
	property p_val; conv_valid_r |-> fall_r <= 4'h4; endproperty
	a_val: assert property (p_val) else $error("valid no fall");
	property p_val_one; conv_valid_r |=> !conv_valid_r; endproperty
	a_val_one: assert property (p_val_one) else $error("long valid");
	property p_err; mode_error_r && $past(mode_error_r) |-> !conv_valid_r; endproperty
	a_err: assert property (p_err) else $error("valid in bad mode");
endmodule // iacs_sva
bind iacs_sequencer iacs_sva u_sva (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
	.data_sample_strobe(data_sample_strobe), .conversion_clock(conversion_clock),
	.mux_channel_r(mux_channel_r), .conv_valid_r(conv_valid_r), .mode_error_r(mode_error_r));
`default_nettype wire

// ---- verification/iacs_ctl.sv ----
// scanner timing controller and sensor levels
`timescale 1ns/1ps
`default_nettype none
module iacs_ctl (
	// clock
	input wire logic clk,
	// strobes, conversion clock, red green blue levels
	output logic ref_s,
	output logic dat_s,
	output logic cnv,
	output logic [47:0] vin
);
	initial {ref_s, dat_s, cnv, vin} = 51'h0;
	// two clocks a level keeps strobe falls clear of conversion edges
	task automatic wt;
		repeat (2) @(posedge clk);
	endtask
	task automatic pixel(input logic correlated_double_sampling, input int n);
		vin <= 48'h9000_8000_7000;
		ref_s <= correlated_double_sampling; // low in sample-and-hold, pulsed while cnv low
		wt();
		ref_s <= 1'b0;
		wt();
		vin <= 48'h1000_2000_3000;
		dat_s <= 1'b1; // after the last conversion fall
		wt();
		dat_s <= 1'b0; // before the first conversion rise
		wt();
		vin <= 48'hefff_dfff_cfff;
		repeat (n) begin
			cnv <= 1'b1;
			wt();
			cnv <= 1'b0;
			wt();
		end
	endtask
endmodule // iacs_ctl
`default_nettype wire

// ---- verification/tb_imaging_afe_channel_sequencer.sv ----
// self-checking bench for the channel sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_imaging_afe_channel_sequencer;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, rd;
	logic ack, rs, ds, cv, vld, clamp, err;
	logic [47:0] vin;
	logic [1:0] ch, mux;
	logic [15:0] dat;
	logic [17:0] got[$];
	int n_fail = 0;
	int num_checks = 0;
	initial forever #12.5 clk = ~clk;
	iacs_ctl u_ctl (.clk(clk), .ref_s(rs), .dat_s(ds), .cnv(cv), .vin(vin));
	iacs_sequencer u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .reference_sample_strobe(rs),
		.data_sample_strobe(ds), .conversion_clock(cv), .vin_red(vin[47:32]), .vin_green(vin[31:16]),
		.vin_blue(vin[15:0]), .offset_level(16'h0800), .mux_channel_r(mux), .conv_data_r(dat),
		.conv_channel_r(ch), .conv_valid_r(vld), .clamp_enable_r(clamp), .mode_error_r(err));
	always @(posedge clk) if (vld === 1'b1) got.push_back({ch, dat});
	task automatic final_report;
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 9);
		rd = rdat;
		cyc <= 1'b0;
		if (ack !== 1'b1) begin
			n_fail++;
			final_report();
		end
	endtask
	// only the newest samples are judged: older ones may still hold the last mode
	task automatic run(input logic [8:0] cfg, mx, input int n, input logic [5:0] ord);
		int k;
		logic [1:0] c;
		wb(1'b1, 8'h00, {23'h0, cfg});
		wb(1'b1, 8'h04, {23'h0, mx});
		got.delete();
		repeat (5) u_ctl.pixel(cfg[4], n);
		// let the last valid pulse be collected before judging
		@(posedge clk);
		chk({30'h0, clamp, err}, {30'h0, cfg[4], 1'b0});
		chk({31'h0, got.size() >= n}, 32'h1);
		for (k = 0; k < n && got.size() >= n; k++) begin
			c = ord[5 - 2 * ((4 * n - 3 + k) % n) -: 2];
			chk({14'h0, got[got.size() - n + k]}, {14'h0, c, cfg[4] ? 16'h8000 - {c, 13'h0} : 16'h0800 + {c, 12'h0}});
		end
		c = ord[5 - 2 * (n - 1) -: 2];
		chk({30'h0, mux}, {30'h0, c});
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, {24'h0, 2'(n - 1), c, 2'(n), cfg[4], 1'b0});
	endtask
	task automatic t_regs;
		chk({31'h0, clamp}, 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_00f8);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0000_00c0);
		wb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_modes;
		run(9'h0f8, 9'h0c0, 3, 6'h06);
		run(9'h0e8, 9'h040, 3, 6'h24);
		run(9'h0d8, 9'h0d0, 2, 6'h08);
		run(9'h0c8, 9'h030, 2, 6'h24);
		run(9'h0d8, 9'h0a0, 1, 6'h10);
		run(9'h0c8, 9'h010, 1, 6'h20);
	endtask
	task automatic t_bad;
		wb(1'b1, 8'h04, 32'h0000_0080);
		got.delete();
		u_ctl.pixel(1'b1, 3);
		chk({31'h0, err}, 32'h1);
		wb(1'b1, 8'h04, 32'h0000_00f0);
		u_ctl.pixel(1'b1, 3);
		chk({30'h0, err, got.size() == 0}, 32'h3);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_modes();
		t_bad();
		final_report();
	end
endmodule // tb_imaging_afe_channel_sequencer
`default_nettype wire
